// ==== t16_pkg.sv ====
// Constants, field positions and carrier types of the sixteen-bit timer.
// Assumes one 100 MHz clock and a CPU port that moves one register per access.
`default_nettype none
package t16_pkg;
	// Register addresses on the CPU register port.
	localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h00;
	localparam logic [7:0] ADDR_MODE_CONTROL = 8'h01;
	localparam logic [7:0] ADDR_OUTPUT_CONTROL = 8'h02;
	localparam logic [7:0] ADDR_PORT3_DIRECTION = 8'h03;
	localparam logic [7:0] ADDR_EDGE_MODE = 8'h04;
	localparam logic [7:0] ADDR_SAMPLING_CLOCK = 8'h05;
	localparam logic [7:0] ADDR_COMPARE = 8'h06;
	localparam logic [7:0] ADDR_CAPTURE = 8'h07;
	localparam logic [7:0] ADDR_COUNT = 8'h08;
	// Values after reset.
	localparam logic [7:0] RST_CLOCK_SELECT = 8'h00;
	localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
	localparam logic [7:0] RST_OUTPUT_CONTROL = 8'h00;
	localparam logic [7:0] RST_PORT3_DIRECTION = 8'hff;
	localparam logic [7:0] RST_EDGE_MODE = 8'h00;
	localparam logic [7:0] RST_SAMPLING_CLOCK = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] RST_COMPARE = 16'hffff;
	localparam logic [15:0] RST_CAPTURE = 16'h0000;
	// Field positions.
	localparam int OVF_BIT = 0;
	localparam int MODE_LSB = 1;
	localparam int CLK_SEL_LSB = 4;
	localparam int OUT_ENABLE_BIT = 0;
	localparam int ACTIVE_LEVEL_BIT = 1;
	localparam int OUT_RESET_BIT = 2;
	localparam int OUT_SET_BIT = 3;
	localparam int EDGE_SEL_LSB = 2;
	localparam int PIN_DIR_BIT = 0;
	// Operating modes, mode select bits 3 to 1.
	localparam logic [2:0] MODE_STOP = 3'h0;
	localparam logic [2:0] MODE_PWM = 3'h1;
	localparam logic [1:0] MODE_FREE = 2'h1;
	localparam logic [1:0] MODE_RESTART = 2'h2;
	localparam logic [1:0] MODE_CLEAR = 2'h3;
	// Count clock codes.
	localparam logic [2:0] CLK_PIN = 3'h0;
	localparam logic [2:0] CLK_DIV1 = 3'h1;
	localparam logic [2:0] CLK_DIV2 = 3'h2;
	localparam logic [2:0] CLK_DIV4 = 3'h3;
	localparam logic [2:0] CLK_DIV8 = 3'h4;
	// Edge select codes.
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Sampling clock masks on the prescaler, for codes 0 to 3.
	localparam logic [6:0] SAMPLE_MASK_0 = 7'h00;
	localparam logic [6:0] SAMPLE_MASK_1 = 7'h0f;
	localparam logic [6:0] SAMPLE_MASK_2 = 7'h3f;
	localparam logic [6:0] SAMPLE_MASK_3 = 7'h7f;
	// One CPU register access.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} t16_req_t;
endpackage : t16_pkg
`default_nettype wire

// ==== t16_timer.sv ====
// Sixteen-bit timer and event counter with capture, PWM and square-wave output.
// Assumes the CPU port and the input pin are synchronous to ref_clk.
//
// What this block does
// - Output set and reset bits always read back as zero.
// - Reset loads the port 3 direction register with all ones.
// - Edge mode register resets to zero; the fourth external interrupt is falling only.
// - Interval mode clears the count on compare match, interrupts and keeps counting.
// - Interval lasts compare value plus one count clocks.
// - Count clock field picks pin edges, main clock, or main divided by 2, 4, 8.
// - Mode code one gives PWM pulses on the timer output pin.
// - PWM width from upper 14 compare bits; polarity from active level bit.
// - PWM has 14-bit resolution from 2^8 basic and 2^6 sub-cycles.
// - Output enable bit turns the timer output on or off.
// - Free-running mode captures the count on each qualified edge and requests interrupt.
// - Two edge select bits choose rising, falling or both edges.
// - Input is sampled at the chosen rate; an edge needs two equal new samples.
// - Restart mode captures the count, then clears it and counts on.
// - Event mode counts qualified edges and clears with interrupt on compare match.
// - With enable and active level bits set, output toggles on every match outside PWM mode.
// - Output set and reset bits establish the initial output level.
// - Stop mode holds the count at zero, keeps output and raises no match interrupt.
// - An edge during a capture read keeps old capture but still requests interrupt.
`timescale 1ns/1ps
`default_nettype none
module t16_timer (
	// Clock, reset and enable
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic ce,
	// CPU register port
	input wire t16_pkg::t16_req_t cpu_req,
	output logic [15:0] cpu_rdata,
	// Pins
	input wire logic timer_input_pin,
	output logic timer_output_pin,
	output logic timer_output_oe,
	// Interrupt requests
	output logic match_interrupt,
	output logic external_edge_interrupt
);
	logic [7:0] clock_select_register;
	logic [7:0] mode_control_register;
	logic [7:0] output_control_register;
	logic [7:0] port3_direction_register;
	logic [7:0] edge_mode_register;
	logic [7:0] sampling_clock_register;
	logic [15:0] compare_register;
	logic [15:0] capture_register;
	logic [15:0] count_register;
	logic [6:0] prescaler;
	logic sample_prev;
	logic level_filtered;
	logic level_delayed;
	logic output_latch;
	logic [2:0] mode;
	logic [2:0] clk_sel;
	logic [6:0] sample_mask;
	logic sample_tick;
	logic rise;
	logic fall;
	logic valid_edge;
	logic count_tick;
	logic running;
	logic is_match;
	logic capture_mode;
	logic capture_reading;
	logic toggle_event;
	logic [8:0] pwm_width;
	logic pwm_level;
	logic wr_sel_outctl;

	assign mode = mode_control_register[t16_pkg::MODE_LSB +: 3];
	assign clk_sel = clock_select_register[t16_pkg::CLK_SEL_LSB +: 3];
	assign running = (mode != t16_pkg::MODE_STOP);
	assign capture_mode = (mode[2:1] == t16_pkg::MODE_FREE) || (mode[2:1] == t16_pkg::MODE_RESTART);
	assign capture_reading = cpu_req.rd && (cpu_req.addr == t16_pkg::ADDR_CAPTURE);
	assign wr_sel_outctl = cpu_req.wr && (cpu_req.addr == t16_pkg::ADDR_OUTPUT_CONTROL);

	// Register writes.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clock_select_register <= t16_pkg::RST_CLOCK_SELECT;
			port3_direction_register <= t16_pkg::RST_PORT3_DIRECTION;
			edge_mode_register <= t16_pkg::RST_EDGE_MODE;
			sampling_clock_register <= t16_pkg::RST_SAMPLING_CLOCK;
			output_control_register <= t16_pkg::RST_OUTPUT_CONTROL;
			compare_register <= t16_pkg::RST_COMPARE;
		end else if (ce && cpu_req.wr) begin
			if (cpu_req.addr == t16_pkg::ADDR_CLOCK_SELECT) begin
				clock_select_register <= cpu_req.wdata[7:0];
			end else if (cpu_req.addr == t16_pkg::ADDR_PORT3_DIRECTION) begin
				port3_direction_register <= cpu_req.wdata[7:0];
			end else if (cpu_req.addr == t16_pkg::ADDR_EDGE_MODE) begin
				edge_mode_register <= cpu_req.wdata[7:0];
			end else if (cpu_req.addr == t16_pkg::ADDR_SAMPLING_CLOCK) begin
				sampling_clock_register <= cpu_req.wdata[7:0];
			end else if (cpu_req.addr == t16_pkg::ADDR_OUTPUT_CONTROL) begin
				// The level bits act as strobes and are never stored.
				output_control_register <= {4'h0, 2'h0, cpu_req.wdata[1:0]};
			end else if (cpu_req.addr == t16_pkg::ADDR_COMPARE) begin
				compare_register <= cpu_req.wdata;
			end
		end
	end

	// Mode register with the sticky overflow flag; an overflow beats a clear.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mode_control_register <= t16_pkg::RST_MODE_CONTROL;
		end else if (ce) begin
			if (cpu_req.wr && cpu_req.addr == t16_pkg::ADDR_MODE_CONTROL) begin
				mode_control_register <= {4'h0, cpu_req.wdata[3:1],
					cpu_req.wdata[0]};
			end
			if (running && count_tick && count_register == 16'hffff) begin
				mode_control_register[t16_pkg::OVF_BIT] <= 1'b1;
			end
		end
	end

	// Free prescaler that makes the divided count clocks and sampling ticks.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prescaler <= 7'h00;
		end else if (ce) begin
			prescaler <= prescaler + 7'h01;
		end
	end

	always_comb begin
		case (sampling_clock_register[1:0])
			2'h0: sample_mask = t16_pkg::SAMPLE_MASK_0;
			2'h1: sample_mask = t16_pkg::SAMPLE_MASK_1;
			2'h2: sample_mask = t16_pkg::SAMPLE_MASK_2;
			default: sample_mask = t16_pkg::SAMPLE_MASK_3;
		endcase
	end
	assign sample_tick = ((prescaler & sample_mask) == sample_mask);

	// Noise filter: a level is taken only when two samples in a row agree.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sample_prev <= 1'b0;
			level_filtered <= 1'b0;
			level_delayed <= 1'b0;
		end else if (ce) begin
			level_delayed <= level_filtered;
			if (sample_tick) begin
				sample_prev <= timer_input_pin;
				if (timer_input_pin == sample_prev) begin
					level_filtered <= timer_input_pin;
				end
			end
		end
	end

	assign rise = level_filtered && !level_delayed;
	assign fall = !level_filtered && level_delayed;
	always_comb begin
		case (edge_mode_register[t16_pkg::EDGE_SEL_LSB +: 2])
			t16_pkg::EDGE_FALL: valid_edge = fall;
			t16_pkg::EDGE_RISE: valid_edge = rise;
			t16_pkg::EDGE_BOTH: valid_edge = rise | fall;
			default: valid_edge = 1'b0;
		endcase
	end

	always_comb begin
		case (clk_sel)
			t16_pkg::CLK_PIN: count_tick = valid_edge;
			t16_pkg::CLK_DIV1: count_tick = 1'b1;
			t16_pkg::CLK_DIV2: count_tick = prescaler[0];
			t16_pkg::CLK_DIV4: count_tick = &prescaler[1:0];
			t16_pkg::CLK_DIV8: count_tick = &prescaler[2:0];
			default: count_tick = 1'b0;
		endcase
	end

	assign is_match = running && count_tick && (count_register == compare_register);

	// Count register.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count_register <= t16_pkg::RST_COUNT;
		end else if (ce) begin
			if (!running) begin
				count_register <= t16_pkg::RST_COUNT;
			end else if (mode[2:1] == t16_pkg::MODE_RESTART && valid_edge) begin
				count_register <= t16_pkg::RST_COUNT;
			end else if (mode[2:1] == t16_pkg::MODE_CLEAR && is_match) begin
				// Counting 0 to N before the clear gives N plus one ticks.
				count_register <= t16_pkg::RST_COUNT;
			end else if (count_tick) begin
				count_register <= count_register + 16'h0001;
			end
		end
	end

	// Capture; a read in progress blocks the copy so software sees a whole word.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			capture_register <= t16_pkg::RST_CAPTURE;
		end else if (ce && running && capture_mode && valid_edge && !capture_reading) begin
			capture_register <= count_register;
		end
	end

	// Interrupt request pulses.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			match_interrupt <= 1'b0;
			external_edge_interrupt <= 1'b0;
		end else if (ce) begin
			match_interrupt <= is_match;
			external_edge_interrupt <= valid_edge;
		end
	end

	// PWM: basic cycle on the low 8 count bits, fraction spread over 64 sub-cycles.
	assign pwm_width = {1'b0, compare_register[15:8]} +
		{8'h00, (count_register[13:8] < compare_register[7:2])};
	assign pwm_level = ({1'b0, count_register[7:0]} < pwm_width) ^
		output_control_register[t16_pkg::ACTIVE_LEVEL_BIT];

	assign toggle_event = running && (mode != t16_pkg::MODE_PWM) &&
		output_control_register[t16_pkg::OUT_ENABLE_BIT] &&
		output_control_register[t16_pkg::ACTIVE_LEVEL_BIT] &&
		(is_match || (mode[0] && valid_edge));

	// Output latch.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			output_latch <= 1'b0;
		end else if (ce) begin
			if (wr_sel_outctl && cpu_req.wdata[t16_pkg::OUT_SET_BIT]) begin
				output_latch <= 1'b1;
			end else if (wr_sel_outctl && cpu_req.wdata[t16_pkg::OUT_RESET_BIT]) begin
				output_latch <= 1'b0;
			end else if (toggle_event) begin
				output_latch <= !output_latch;
			end
		end
	end

	// Output pin; driven only while the shared pin is set to output.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			timer_output_pin <= 1'b0;
			timer_output_oe <= 1'b0;
		end else if (ce) begin
			timer_output_oe <= !port3_direction_register[t16_pkg::PIN_DIR_BIT];
			if (!output_control_register[t16_pkg::OUT_ENABLE_BIT]) begin
				timer_output_pin <= 1'b0;
			end else if (mode == t16_pkg::MODE_PWM) begin
				timer_output_pin <= pwm_level;
			end else begin
				timer_output_pin <= output_latch;
			end
		end
	end

	// Read data, valid the cycle after the read strobe.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cpu_rdata <= 16'h0000;
		end else if (ce && cpu_req.rd) begin
			if (cpu_req.addr == t16_pkg::ADDR_CLOCK_SELECT) begin
				cpu_rdata <= {8'h00, clock_select_register};
			end else if (cpu_req.addr == t16_pkg::ADDR_MODE_CONTROL) begin
				cpu_rdata <= {8'h00, mode_control_register};
			end else if (cpu_req.addr == t16_pkg::ADDR_OUTPUT_CONTROL) begin
				cpu_rdata <= {8'h00, output_control_register};
			end else if (cpu_req.addr == t16_pkg::ADDR_PORT3_DIRECTION) begin
				cpu_rdata <= {8'h00, port3_direction_register};
			end else if (cpu_req.addr == t16_pkg::ADDR_EDGE_MODE) begin
				cpu_rdata <= {8'h00, edge_mode_register};
			end else if (cpu_req.addr == t16_pkg::ADDR_SAMPLING_CLOCK) begin
				cpu_rdata <= {8'h00, sampling_clock_register};
			end else if (cpu_req.addr == t16_pkg::ADDR_COMPARE) begin
				cpu_rdata <= compare_register;
			end else if (cpu_req.addr == t16_pkg::ADDR_CAPTURE) begin
				cpu_rdata <= capture_register;
			end else if (cpu_req.addr == t16_pkg::ADDR_COUNT) begin
				cpu_rdata <= count_register;
			end else begin
				cpu_rdata <= 16'h0000;
			end
		end
	end

	// Checks.
	sequence clear_match_s;
		ce && mode[2:1] == t16_pkg::MODE_CLEAR && is_match;
	endsequence
	sequence cleared_irq_s;
		count_register == 16'h0000 && match_interrupt;
	endsequence
	property interval_p;
		@(posedge ref_clk) disable iff (!nrst) clear_match_s |=> cleared_irq_s;
	endproperty
	interval_clear_a: assert property (interval_p) else $error("count not cleared on match");
	level_read_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && cpu_req.rd && cpu_req.addr == t16_pkg::ADDR_OUTPUT_CONTROL |=> cpu_rdata[3:2] == 2'h0)
		else $error("level bits read nonzero");
	port_reset_a: assert property (@(posedge ref_clk) $rose(nrst) |->
		port3_direction_register == t16_pkg::RST_PORT3_DIRECTION)
		else $error("port direction not all ones");
	stop_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && !running |=> count_register == 16'h0000 && !match_interrupt)
		else $error("stopped timer moved");
	edge_capture_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && running && capture_mode && valid_edge && !capture_reading |=>
		capture_register == $past(count_register) && external_edge_interrupt)
		else $error("capture missed");
	restart_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && mode[2:1] == t16_pkg::MODE_RESTART && valid_edge |=> count_register == 16'h0000)
		else $error("restart did not clear");
	read_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && valid_edge && capture_reading |=> $stable(capture_register) && external_edge_interrupt)
		else $error("capture changed during read");
	event_step_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && mode[2:1] == t16_pkg::MODE_CLEAR && clk_sel == t16_pkg::CLK_PIN && valid_edge &&
		count_register != compare_register |=> count_register == $past(count_register) + 16'h0001)
		else $error("event not counted");
	square_toggle_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && toggle_event && !wr_sel_outctl |=> output_latch != $past(output_latch))
		else $error("output did not toggle");
	out_disable_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		ce && !output_control_register[t16_pkg::OUT_ENABLE_BIT] |=> !timer_output_pin)
		else $error("disabled output high");
endmodule : t16_timer
`default_nettype wire

// ==== t16_pulse_src.sv ====
// Model of the external pulse source that drives the timer input pin.
// Assumes it shares ref_clk with the timer and is started by a one-cycle go pulse.
`timescale 1ns/1ps
`default_nettype none
module t16_pulse_src (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Pulse train request
	input wire logic go,
	input wire logic [7:0] hi_len,
	input wire logic [7:0] period,
	input wire logic [3:0] pulses,
	// Pin side
	output logic busy,
	output logic timer_input_pin
);
	logic [7:0] phase;
	logic [3:0] left;
	// The pin rests low between trains, so an idle line never looks like an edge.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			phase <= 8'h00;
			left <= 4'h0;
		end else if (go) begin
			phase <= 8'h00;
			left <= pulses;
		end else if (left != 4'h0) begin
			phase <= (phase == period - 8'h01) ? 8'h00 : phase + 8'h01;
			if (phase == period - 8'h01) begin
				left <= left - 4'h1;
			end
		end
	end
	assign busy = (left != 4'h0);
	assign timer_input_pin = (left != 4'h0) && (phase < hi_len);
endmodule : t16_pulse_src
`default_nettype wire

// ==== t16_timer_bench.sv ====
// Self-checking bench for the sixteen-bit timer, driven through its register port.
// Assumes the design and the pulse source model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module t16_timer_bench;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic go = 1'b0;
	logic ce = 1'b1;
	t16_pkg::t16_req_t req = '0;
	logic [7:0] hi_len = 8'h03;
	logic [7:0] period = 8'h0a;
	logic [3:0] pulses = 4'h1;
	logic [15:0] rdata, v, c1, c2;
	logic pin, out_pin, oe, m_irq, e_irq, busy;
	int fail_count = 0, tests_run = 0, m_cnt = 0, e_cnt = 0, hi_cnt = 0, cyc = 0, t1, t2;
	logic [7:0] edges [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
	int exp_e [4] = '{2, 2, 0, 4};

	always #5 ref_clk = ~ref_clk;

	t16_timer i_t16_timer (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .cpu_req(req),
		.cpu_rdata(rdata), .timer_input_pin(pin), .timer_output_pin(out_pin),
		.timer_output_oe(oe), .match_interrupt(m_irq), .external_edge_interrupt(e_irq));
	t16_pulse_src i_t16_pulse_src (.ref_clk(ref_clk), .nrst(nrst), .go(go), .hi_len(hi_len),
		.period(period), .pulses(pulses), .busy(busy), .timer_input_pin(pin));

	always @(posedge ref_clk) begin
		cyc++;
		if (m_irq === 1'b1) m_cnt++;
		if (e_irq === 1'b1) e_cnt++;
		if (out_pin === 1'b1) hi_cnt++;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		@(posedge ref_clk);
		#1;
		d = rdata;
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		rd(a, v);
		chk(v, exp);
	endtask : rdc

	// A missing pulse counts as one mismatch instead of hanging the run.
	task automatic wait_irq(input logic match, output int t);
		t = -1;
		for (int i = 0; i < 3000 && t < 0; i++) begin
			@(posedge ref_clk);
			#1;
			if ((match ? m_irq : e_irq) === 1'b1) t = cyc;
		end
		if (t < 0) chk(16'h0001, 16'h0000);
	endtask : wait_irq

	task automatic burst(input logic [7:0] h, input logic [7:0] p, input logic [3:0] n);
		@(posedge ref_clk);
		hi_len <= h;
		period <= p;
		pulses <= n;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		repeat (2) @(posedge ref_clk);
		for (int i = 0; i < 3000 && busy; i++) @(posedge ref_clk);
		repeat (12) @(posedge ref_clk);
	endtask : burst

	task automatic setup(input logic [7:0] clk_sel, input logic [7:0] edge_m, input logic [7:0] mode);
		wr(t16_pkg::ADDR_MODE_CONTROL, 16'h0000);
		wr(t16_pkg::ADDR_CLOCK_SELECT, {8'h00, clk_sel});
		wr(t16_pkg::ADDR_EDGE_MODE, {8'h00, edge_m});
		wr(t16_pkg::ADDR_MODE_CONTROL, {8'h00, mode});
	endtask : setup

	task automatic meas(input logic [7:0] mode);
		setup(8'h10, 8'h04, mode);
		fork
			burst(8'h03, 8'h28, 4'h2);
			begin
				wait_irq(1'b0, t1);
				rd(t16_pkg::ADDR_CAPTURE, c1);
				wait_irq(1'b0, t2);
				rd(t16_pkg::ADDR_CAPTURE, c2);
			end
		join
	endtask : meas

	task automatic win(input int n, input logic [15:0] exp);
		repeat (300) @(posedge ref_clk);
		#1;
		hi_cnt = 0;
		repeat (n) @(posedge ref_clk);
		#1;
		chk(16'(hi_cnt), exp);
	endtask : win

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	// The whole sequence needs about a fifth of a millisecond; this limit leaves slack.
	initial begin
		#600000;
		fail_count++;
		complete_run();
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk({15'h0000, oe}, 16'h0000);
		rdc(t16_pkg::ADDR_PORT3_DIRECTION, 16'h00ff);
		rdc(t16_pkg::ADDR_EDGE_MODE, 16'h0000);
		rdc(t16_pkg::ADDR_SAMPLING_CLOCK, 16'h0000);
		rdc(t16_pkg::ADDR_CLOCK_SELECT, 16'h0000);
		rdc(t16_pkg::ADDR_COUNT, 16'h0000);
		rdc(8'h20, 16'h0000);
		wr(t16_pkg::ADDR_OUTPUT_CONTROL, 16'h000c);
		rdc(t16_pkg::ADDR_OUTPUT_CONTROL, 16'h0000);
		wr(t16_pkg::ADDR_PORT3_DIRECTION, 16'h00fe);
		repeat (2) @(posedge ref_clk);
		#1;
		chk({15'h0000, oe}, 16'h0001);
		wr(t16_pkg::ADDR_COMPARE, 16'h0003);
		for (int k = 1; k <= 4; k++) begin
			setup(8'(k << 4), 8'h00, 8'h0c);
			wait_irq(1'b1, t1);
			wait_irq(1'b1, t1);
			wait_irq(1'b1, t2);
			chk(16'(t2 - t1), 16'(4 << (k - 1)));
		end
		// Clock enable low must freeze the running interval timer, so no match can occur.
		@(posedge ref_clk);
		ce <= 1'b0;
		@(posedge ref_clk);
		#1;
		m_cnt = 0;
		repeat (100) @(posedge ref_clk);
		ce <= 1'b1;
		chk(16'(m_cnt), 16'h0000);
		wr(t16_pkg::ADDR_MODE_CONTROL, 16'h0000);
		rdc(t16_pkg::ADDR_COUNT, 16'h0000);
		m_cnt = 0;
		repeat (60) @(posedge ref_clk);
		chk(16'(m_cnt), 16'h0000);
		wr(t16_pkg::ADDR_OUTPUT_CONTROL, 16'h000b);
		repeat (3) @(posedge ref_clk);
		#1;
		chk({15'h0000, out_pin}, 16'h0001);
		setup(8'h10, 8'h00, 8'h0c);
		for (int k = 0; k < 2; k++) begin
			wait_irq(1'b1, t1);
			@(posedge ref_clk);
			#1;
			chk({15'h0000, out_pin}, 16'(k));
		end
		wr(t16_pkg::ADDR_MODE_CONTROL, 16'h0000);
		wr(t16_pkg::ADDR_OUTPUT_CONTROL, 16'h0007);
		repeat (3) @(posedge ref_clk);
		#1;
		chk({15'h0000, out_pin}, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			setup(8'h10, edges[k], 8'h04);
			e_cnt = 0;
			burst(8'h03, 8'h0a, 4'h2);
			chk(16'(e_cnt), 16'(exp_e[k]));
		end
		e_cnt = 0;
		burst(8'h01, 8'h0a, 4'h2);
		chk(16'(e_cnt), 16'h0000);
		burst(8'h02, 8'h0a, 4'h2);
		chk(16'(e_cnt), 16'h0004);
		wr(t16_pkg::ADDR_SAMPLING_CLOCK, 16'h0001);
		e_cnt = 0;
		burst(8'h08, 8'h50, 4'h1);
		chk(16'(e_cnt), 16'h0000);
		burst(8'h28, 8'h50, 4'h1);
		chk(16'(e_cnt), 16'h0002);
		wr(t16_pkg::ADDR_SAMPLING_CLOCK, 16'h0000);
		meas(8'h04);
		chk(c2 - c1, 16'h0028);
		meas(8'h08);
		chk(c2, 16'h0027);
		setup(8'h10, 8'h04, 8'h04);
		rd(t16_pkg::ADDR_CAPTURE, c1);
		e_cnt = 0;
		@(posedge ref_clk);
		hi_len <= 8'h0a;
		period <= 8'h14;
		pulses <= 4'h1;
		go <= 1'b1;
		req <= '{wr: 1'b0, rd: 1'b1, addr: t16_pkg::ADDR_CAPTURE, wdata: 16'h0000};
		@(posedge ref_clk);
		go <= 1'b0;
		repeat (12) @(posedge ref_clk);
		req.rd <= 1'b0;
		repeat (30) @(posedge ref_clk);
		rdc(t16_pkg::ADDR_CAPTURE, c1);
		chk(16'(e_cnt), 16'h0001);
		wr(t16_pkg::ADDR_COMPARE, 16'h0002);
		setup(8'h00, 8'h04, 8'h0c);
		m_cnt = 0;
		burst(8'h03, 8'h0a, 4'h2);
		rdc(t16_pkg::ADDR_COUNT, 16'h0002);
		chk(16'(m_cnt), 16'h0000);
		burst(8'h03, 8'h0a, 4'h1);
		rdc(t16_pkg::ADDR_COUNT, 16'h0000);
		chk(16'(m_cnt), 16'h0001);
		setup(8'h00, 8'h04, 8'h0e);
		#1;
		c1 = {15'h0000, out_pin};
		burst(8'h03, 8'h0a, 4'h1);
		chk({15'h0000, out_pin}, c1 ^ 16'h0001);
		setup(8'h10, 8'h00, 8'h02);
		wr(t16_pkg::ADDR_COMPARE, 16'h4000);
		wr(t16_pkg::ADDR_OUTPUT_CONTROL, 16'h0001);
		win(256, 16'd64);
		wr(t16_pkg::ADDR_OUTPUT_CONTROL, 16'h0003);
		win(256, 16'd192);
		wr(t16_pkg::ADDR_OUTPUT_CONTROL, 16'h0000);
		win(256, 16'h0000);
		wr(t16_pkg::ADDR_OUTPUT_CONTROL, 16'h0001);
		wr(t16_pkg::ADDR_COMPARE, 16'h4004);
		win(16384, 16'd4097);
		complete_run();
	end
endmodule : t16_timer_bench
`default_nettype wire
